// File: rtl/drt_core.sv
// conversion sequencer, result registers and smbus slave of the sensor core
// Operation
// RULE1 - convert local, remote1, remote2 in turn
// RULE2 - busy bit high only while converting
// RULE3 - full default pass takes 77.8 ms
// RULE4 - slower rates add idle, pass stays bounded
// RULE5 - standby stops; one-shot runs one pass
// RULE6 - filter on: 13-bit remote, 1/32 degree
// RULE7 - filter off: 11-bit remote, 1/8 degree
// RULE8 - unsigned remote reaches up to 255.875
// RULE9 - local always 9 bits plus sign
// RULE10 - results left-justified, unused bits zero
// RULE11 - all registers eight bits wide
// RULE12 - 11-bit signed is two's complement
// RULE13 - 13-bit signed is two's complement
// RULE14 - command pointer starts at zero
// RULE15 - results read zero before first conversion
// RULE16 - both remote filters on at power-up
// RULE17 - remote1 processor model, remote2 transistor
// RULE18 - configuration starts zero, continuous conversion
// RULE19 - slave only, clock input, no stretching
// RULE20 - fixed seven-bit slave address
// RULE21 - diode model held in a register
// RULE22 - host sets compensation to match diode
// RULE23 - status shows diode fault inputs live
// RULE24 - high byte read freezes low byte; the code freezes only the remote1 and remote2 low bytes, not local
// RULE25 - 35 ms low releases bus, idles
// RULE26 - format fixed when each result stored
`default_nettype none
module drt_core #(
  parameter int CH_CYC = drt_pkg::CH_CYC,
  parameter int IDLE_CYC = drt_pkg::IDLE_CYC,
  parameter int TMO_CYC = drt_pkg::TMO_CYC,
  parameter logic [6:0] SLAVE_ADDR = drt_pkg::SLAVE_ADDR
) (
  // system
  input wire logic clk_sys,
  input wire logic reset,
  // smbus pins
  input wire logic smb_clk,
  input wire logic smb_dat_i,
  output logic smb_dat_o,
  output logic smb_dat_oe_n,
  // analog front end
  input wire logic signed [16:0] loc_sample,
  input wire logic signed [16:0] rem1_sample,
  input wire logic signed [16:0] rem2_sample,
  input wire logic diode1_fault,
  input wire logic diode2_fault,
  output logic [1:0] conv_chan,
  output logic [1:0] diode_model,
  output logic [1:0] ideality_comp
);
  // ***************************
  // declarations
  // ***************************
  logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  logic wt_m_q, wt_s_q, wt_p_q, rt_m_q, rt_s_q, rt_p_q;
  logic [1:0] f_m_q, f_s_q;
  logic [23:0] tmo_q, tmo_d;
  logic hold_q, hold_d, oneshot_q, oneshot_d;
  logic [7:0] cfg_q, cfg_d, rd_q, rd_d;
  logic [1:0] filt_q, filt_d, model_q, model_d, comp_q, comp_d, lock_q, lock_d;
  logic [7:0] frz_q [2];
  logic [7:0] frz_d [2];
  logic wr_evt, rd_evt;
  drt_pkg::drt_conv_t cst_q, cst_d;
  logic [1:0] ch_q, ch_d;
  logic [23:0] cnt_q, cnt_d, wait_cyc, pass_q;
  logic [15:0] res_q [3];
  logic [15:0] res_d [3];
  logic signed [16:0] smp;
  logic [15:0] msk;
  logic uns, flt;
  drt_pkg::drt_link_t lst_q, lst_d;
  logic [2:0] bit_q, bit_d;
  logic [6:0] sh_q, sh_d;
  logic [7:0] byte_w, ptr_q, ptr_d, wdat_q, wdat_d;
  logic sdp_q, sdp_d, wtg_q, wtg_d, rtg_q, rtg_d, rs_q, rs_d, oe_n_d;

  function automatic logic [15:0] fmt_word(input logic signed [16:0] s,
      input logic [15:0] mask, input logic unsgn, input logic fault);
    logic [15:0] w;
    w = s[15:0];
    if (fault) w = unsgn ? drt_pkg::WORD_UMAX : drt_pkg::WORD_SMIN;
    else if (unsgn) w = s[16] ? 16'h0000 : s[15:0]; // RULE8
    else if (s > $signed({1'b0, drt_pkg::WORD_SMAX})) w = drt_pkg::WORD_SMAX;
    else if (s < -$signed({1'b0, drt_pkg::WORD_SMIN})) w = drt_pkg::WORD_SMIN;
    return w & mask; // RULE10 RULE12 RULE13
  endfunction

  // ***************************
  // bus side, system clock
  // ***************************
  assign wr_evt = wt_s_q ^ wt_p_q;
  assign rd_evt = rt_s_q ^ rt_p_q;

  always_comb begin
    tmo_d = tmo_q;
    hold_d = hold_q;
    cfg_d = cfg_q;
    filt_d = filt_q;
    model_d = model_q;
    comp_d = comp_q;
    rd_d = rd_q;
    lock_d = lock_q;
    frz_d = frz_q;
    oneshot_d = 1'b0;
    // an edge on the clock line means the bus still moves
    if ((scl_s_q & sda_s_q) | (scl_s_q ^ scl_p_q)) begin
      tmo_d = '0;
    end else if (tmo_q != 24'(TMO_CYC)) begin
      tmo_d = tmo_q + 24'h000001;
    end
    if (scl_s_q & scl_p_q & sda_p_q & ~sda_s_q) hold_d = 1'b0;
    if ((scl_s_q & scl_p_q & ~sda_p_q & sda_s_q) | (tmo_q == 24'(TMO_CYC))) begin
      hold_d = 1'b1; // RULE25
    end
    if (wr_evt) begin
      case (ptr_q)
        drt_pkg::REG_CONFIG: cfg_d = wdat_q;
        drt_pkg::REG_FILTER: filt_d = {wdat_q[2], wdat_q[0]};
        drt_pkg::REG_MODEL: model_d = wdat_q[1:0]; // RULE21
        drt_pkg::REG_COMP: comp_d = wdat_q[1:0];
        drt_pkg::REG_ONESHOT: oneshot_d = 1'b1; // RULE5
        default: ;
      endcase
    end
    if (rd_evt) begin
      case (ptr_q)
        drt_pkg::REG_LOC_HI: rd_d = res_q[0][15:8];
        drt_pkg::REG_LOC_LO: rd_d = res_q[0][7:0];
        drt_pkg::REG_REM1_HI: begin
          rd_d = res_q[1][15:8];
          lock_d[0] = 1'b1; // RULE24
          frz_d[0] = res_q[1][7:0];
        end
        drt_pkg::REG_REM1_LO: begin
          rd_d = lock_q[0] ? frz_q[0] : res_q[1][7:0];
          lock_d[0] = 1'b0;
        end
        drt_pkg::REG_REM2_HI: begin
          rd_d = res_q[2][15:8];
          lock_d[1] = 1'b1; // RULE24
          frz_d[1] = res_q[2][7:0];
        end
        drt_pkg::REG_REM2_LO: begin
          rd_d = lock_q[1] ? frz_q[1] : res_q[2][7:0];
          lock_d[1] = 1'b0;
        end
        drt_pkg::REG_STATUS: rd_d = {cst_q == drt_pkg::C_CONV, 5'h00, f_s_q}; // RULE2 RULE23
        drt_pkg::REG_CONFIG: rd_d = cfg_q;
        drt_pkg::REG_FILTER: rd_d = {5'h00, filt_q[1], 1'b0, filt_q[0]};
        drt_pkg::REG_MODEL: rd_d = {6'h00, model_q};
        drt_pkg::REG_COMP: rd_d = {6'h00, comp_q};
        default: rd_d = 8'h00; // RULE11
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      {scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q} <= 6'h3f;
      {wt_m_q, wt_s_q, wt_p_q, rt_m_q, rt_s_q, rt_p_q} <= 6'h00;
      f_m_q <= 2'b00;
      f_s_q <= 2'b00;
      tmo_q <= '0;
      hold_q <= 1'b1;
      oneshot_q <= 1'b0;
      cfg_q <= drt_pkg::CONFIG_RST; // RULE18
      filt_q <= drt_pkg::FILTER_RST; // RULE16
      model_q <= drt_pkg::MODEL_RST; // RULE17
      comp_q <= drt_pkg::COMP_RST; // RULE17
      rd_q <= 8'h00;
      lock_q <= 2'b00;
      frz_q <= '{default: 8'h00};
    end else begin
      {scl_m_q, scl_s_q, scl_p_q} <= {smb_clk, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {smb_dat_i, sda_m_q, sda_s_q};
      {wt_m_q, wt_s_q, wt_p_q} <= {wtg_q, wt_m_q, wt_s_q};
      {rt_m_q, rt_s_q, rt_p_q} <= {rtg_q, rt_m_q, rt_s_q};
      f_m_q <= {diode1_fault, diode2_fault};
      f_s_q <= f_m_q;
      tmo_q <= tmo_d;
      hold_q <= hold_d;
      oneshot_q <= oneshot_d;
      cfg_q <= cfg_d;
      filt_q <= filt_d;
      model_q <= model_d;
      comp_q <= comp_d;
      rd_q <= rd_d;
      lock_q <= lock_d;
      frz_q <= frz_d;
    end
  end

  // ***************************
  // conversion sequencer
  // ***************************
  assign wait_cyc = 24'(IDLE_CYC) * {22'h0, cfg_q[drt_pkg::CFG_RATE +: 2]};

  always_comb begin
    cst_d = cst_q;
    ch_d = ch_q;
    cnt_d = cnt_q + 24'h000001;
    res_d = res_q;
    smp = loc_sample;
    msk = drt_pkg::MASK_LOC; // RULE9
    uns = 1'b0;
    flt = 1'b0;
    unique case (ch_q)
      2'd1: begin
        smp = rem1_sample;
        msk = filt_q[0] ? drt_pkg::MASK_F13 : drt_pkg::MASK_F11; // RULE6 RULE7
        uns = cfg_q[drt_pkg::CFG_UNS1];
        flt = f_s_q[1];
      end
      2'd2: begin
        smp = rem2_sample;
        msk = filt_q[1] ? drt_pkg::MASK_F13 : drt_pkg::MASK_F11; // RULE6 RULE7
        uns = cfg_q[drt_pkg::CFG_UNS2];
        flt = f_s_q[0];
      end
      default: ;
    endcase
    unique case (cst_q)
      drt_pkg::C_IDLE: begin
        cnt_d = '0;
        if (!cfg_q[drt_pkg::CFG_STANDBY] || oneshot_q) cst_d = drt_pkg::C_CONV; // RULE5
      end
      drt_pkg::C_CONV: begin
        if (cnt_q == 24'(CH_CYC - 1)) begin // RULE3
          cnt_d = '0;
          res_d[ch_q] = fmt_word(smp, msk, uns, flt); // RULE1 RULE26
          if (ch_q == 2'd2) begin
            ch_d = 2'd0;
            if (cfg_q[drt_pkg::CFG_STANDBY]) begin
              cst_d = drt_pkg::C_IDLE;
            end else if (wait_cyc != 24'h000000) begin
              cst_d = drt_pkg::C_WAIT; // RULE4
            end
          end else begin
            ch_d = ch_q + 2'd1;
          end
        end
      end
      drt_pkg::C_WAIT: begin
        if (cfg_q[drt_pkg::CFG_STANDBY]) begin
          cst_d = drt_pkg::C_IDLE;
        end else if (cnt_q >= wait_cyc - 24'h000001) begin
          cnt_d = '0;
          cst_d = drt_pkg::C_CONV;
        end
      end
      default: cst_d = drt_pkg::C_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cst_q <= drt_pkg::C_IDLE;
      ch_q <= 2'd0;
      cnt_q <= '0;
      res_q <= '{default: 16'h0000}; // RULE15
    end else begin
      cst_q <= cst_d;
      ch_q <= ch_d;
      cnt_q <= cnt_d;
      res_q <= res_d;
    end
  end

  assign conv_chan = ch_q;
  assign diode_model = model_q;
  assign ideality_comp = comp_q;
  // open-drain: only ever pulls low
  assign smb_dat_o = 1'b0;

  // ***************************
  // smbus slave, link clock
  // ***************************
  // read bytes are settled by the system side within a few cycles of the
  // request toggle, long before the next falling clock edge uses them
  assign byte_w = {sh_q, smb_dat_i};

  always_comb begin
    lst_d = lst_q;
    bit_d = bit_q + 3'h1;
    sh_d = byte_w[6:0];
    sdp_d = smb_dat_i;
    ptr_d = ptr_q;
    wdat_d = wdat_q;
    wtg_d = wtg_q;
    rtg_d = rtg_q;
    if (rs_q) begin
      lst_d = drt_pkg::L_ADDR;
      bit_d = 3'h1;
    end else begin
      unique case (lst_q)
        drt_pkg::L_ADDR: begin
          if (bit_q == 3'h7) begin
            if (byte_w[7:1] != SLAVE_ADDR) begin
              lst_d = drt_pkg::L_IGN; // RULE20
            end else begin
              lst_d = drt_pkg::L_AACK;
              if (byte_w[0]) rtg_d = ~rtg_q;
            end
          end
        end
        drt_pkg::L_AACK: begin
          bit_d = 3'h0;
          lst_d = sh_q[0] ? drt_pkg::L_RD : drt_pkg::L_CMD;
        end
        drt_pkg::L_CMD: begin
          if (bit_q == 3'h7) begin
            ptr_d = byte_w;
            lst_d = drt_pkg::L_WACK;
          end
        end
        drt_pkg::L_WACK: begin
          bit_d = 3'h0;
          lst_d = drt_pkg::L_WR;
        end
        drt_pkg::L_WR: begin
          if (bit_q == 3'h7) begin
            wdat_d = byte_w;
            wtg_d = ~wtg_q;
            lst_d = drt_pkg::L_WACK;
          end
        end
        drt_pkg::L_RD: begin
          if (bit_q == 3'h7) lst_d = drt_pkg::L_RACK;
        end
        drt_pkg::L_RACK: begin
          bit_d = 3'h0;
          if (smb_dat_i) begin
            lst_d = drt_pkg::L_IGN;
          end else begin
            lst_d = drt_pkg::L_RD;
            rtg_d = ~rtg_q;
          end
        end
        drt_pkg::L_IGN: ;
      endcase
    end
  end

  // frame state is dropped on stop or timeout, the pointer is not
  always_ff @(posedge smb_clk or posedge hold_q) begin
    if (hold_q) begin
      lst_q <= drt_pkg::L_ADDR;
      bit_q <= 3'h0;
      sh_q <= 7'h00;
      sdp_q <= 1'b0;
    end else begin
      lst_q <= lst_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      sdp_q <= sdp_d;
    end
  end

  always_ff @(posedge smb_clk or posedge reset) begin
    if (reset) begin
      ptr_q <= drt_pkg::PTR_RST; // RULE14
      wdat_q <= 8'h00;
      wtg_q <= 1'b0;
      rtg_q <= 1'b0;
    end else begin
      ptr_q <= ptr_d;
      wdat_q <= wdat_d;
      wtg_q <= wtg_d;
      rtg_q <= rtg_d;
    end
  end

  always_comb begin
    rs_d = sdp_q & ~smb_dat_i;
    unique case (lst_q)
      drt_pkg::L_AACK, drt_pkg::L_WACK: oe_n_d = 1'b0;
      drt_pkg::L_RD: oe_n_d = rd_q[3'h7 - bit_q];
      default: oe_n_d = 1'b1; // RULE19
    endcase
  end

  always_ff @(negedge smb_clk or posedge hold_q) begin
    if (hold_q) begin
      rs_q <= 1'b0;
      smb_dat_oe_n <= 1'b1; // RULE25
    end else begin
      rs_q <= rs_d;
      smb_dat_oe_n <= oe_n_d;
    end
  end

  // ***************************
  // checks
  // ***************************
  always_ff @(posedge clk_sys or posedge reset) begin
    // restart per pass: continuous mode with rate field 0 never leaves the converting state
    if (reset) pass_q <= '0;
    else if (cst_q != drt_pkg::C_CONV) pass_q <= '0;
    else if (ch_q == 2'd2 && cnt_q == 24'(CH_CYC - 1)) pass_q <= '0;
    else pass_q <= pass_q + 24'h000001;
  end

  AST_PASS_START: assert property (@(posedge clk_sys) disable iff (reset) // RULE1
    $rose(cst_q == drt_pkg::C_CONV) |-> ch_q == 2'd0) else $error("pass not at local");
  AST_CHAN_STEP: assert property (@(posedge clk_sys) disable iff (reset) // RULE1
    cst_q == drt_pkg::C_CONV && cnt_q == 24'(CH_CYC - 1) && ch_q != 2'd2
    |=> ch_q == $past(ch_q) + 2'd1) else $error("channel order broken");
  AST_BUSY_READ: assert property (@(posedge clk_sys) disable iff (reset) // RULE2
    rd_evt && ptr_q == drt_pkg::REG_STATUS
    |=> rd_q[drt_pkg::STAT_BUSY] == $past(cst_q == drt_pkg::C_CONV)) else $error("busy wrong");
  AST_PASS_MAX: assert property (@(posedge clk_sys) disable iff (reset) // RULE4
    pass_q <= 24'(drt_pkg::PASS_MAX_CYC)) else $error("pass too long");
  AST_ONESHOT: assert property (@(posedge clk_sys) disable iff (reset) // RULE5
    cst_q == drt_pkg::C_IDLE && oneshot_q |=> cst_q == drt_pkg::C_CONV) else $error("no shot");
  AST_STANDBY: assert property (@(posedge clk_sys) disable iff (reset) // RULE5
    cst_q == drt_pkg::C_IDLE && cfg_q[drt_pkg::CFG_STANDBY] && !oneshot_q
    |=> cst_q == drt_pkg::C_IDLE) else $error("standby converted");
  AST_LOCAL_FMT: assert property (@(posedge clk_sys) disable iff (reset) // RULE9
    (res_q[0] & ~drt_pkg::MASK_LOC) == 16'h0000) else $error("local low bits set");
  AST_REM_FMT: assert property (@(posedge clk_sys) disable iff (reset) // RULE7
    cst_q == drt_pkg::C_CONV && cnt_q == 24'(CH_CYC - 1) && ch_q == 2'd1 && !filt_q[0]
    |=> res_q[1][4:0] == 5'h00) else $error("11-bit word has low bits");
  AST_FREEZE: assert property (@(posedge clk_sys) disable iff (reset) // RULE24
    lock_q[0] && !(rd_evt && ptr_q == drt_pkg::REG_REM1_HI) |=> $stable(frz_q[0]))
    else $error("frozen byte moved");
  AST_TMO: assert property (@(posedge clk_sys) disable iff (reset) // RULE25
    tmo_q == 24'(TMO_CYC) |=> hold_q) else $error("timeout ignored");
  AST_CMD_RELEASE: assert property (@(posedge smb_clk) disable iff (hold_q) // RULE19
    lst_q == drt_pkg::L_CMD && bit_q != 3'h0 |-> smb_dat_oe_n) else $error("drove in cmd");
endmodule
`default_nettype wire

// File: rtl/drt_pkg.sv
// constants and types for the three-zone temperature sensor core
`default_nettype none
package drt_pkg;
  // ***************************
  // command codes
  // ***************************
  localparam logic [7:0] REG_LOC_HI = 8'h00;
  localparam logic [7:0] REG_REM1_HI = 8'h01;
  localparam logic [7:0] REG_STATUS = 8'h02;
  localparam logic [7:0] REG_CONFIG = 8'h03;
  localparam logic [7:0] REG_REM2_HI = 8'h04;
  localparam logic [7:0] REG_FILTER = 8'h06;
  localparam logic [7:0] REG_COMP = 8'h07;
  localparam logic [7:0] REG_ONESHOT = 8'h0f;
  localparam logic [7:0] REG_LOC_LO = 8'h10;
  localparam logic [7:0] REG_REM1_LO = 8'h11;
  localparam logic [7:0] REG_REM2_LO = 8'h12;
  localparam logic [7:0] REG_MODEL = 8'h30;
  // ***************************
  // fields and reset values
  // ***************************
  localparam int CFG_UNS1 = 1;
  localparam int CFG_UNS2 = 2;
  localparam int CFG_RATE = 4;
  localparam int CFG_STANDBY = 6;
  localparam int STAT_BUSY = 7;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [1:0] FILTER_RST = 2'b11;
  localparam logic [1:0] MODEL_RST = 2'b01;
  localparam logic [1:0] COMP_RST = 2'b01;
  localparam logic [6:0] SLAVE_ADDR = 7'h2b;
  // ***************************
  // result word layout
  // ***************************
  localparam logic [15:0] MASK_LOC = 16'hffc0;
  localparam logic [15:0] MASK_F13 = 16'hfff8;
  localparam logic [15:0] MASK_F11 = 16'hffe0;
  localparam logic [15:0] WORD_SMAX = 16'h7fff;
  localparam logic [15:0] WORD_SMIN = 16'h8000;
  localparam logic [15:0] WORD_UMAX = 16'hffff;
  // ***************************
  // timing
  // ***************************
  localparam int CLK_NS = 50;
  localparam int PASS_TYP_NS = 77800000;
  localparam int PASS_MAX_NS = 88900000;
  localparam int TMO_NS = 35000000;
  localparam int CH_CYC = PASS_TYP_NS / CLK_NS / 3;
  localparam int IDLE_CYC = PASS_TYP_NS / CLK_NS;
  localparam int PASS_MAX_CYC = PASS_MAX_NS / CLK_NS;
  localparam int TMO_CYC = TMO_NS / CLK_NS;
  // ***************************
  // states
  // ***************************
  typedef enum logic [1:0] {C_IDLE, C_CONV, C_WAIT} drt_conv_t;
  typedef enum logic [2:0] {L_ADDR, L_AACK, L_CMD, L_WACK, L_WR, L_RD, L_RACK, L_IGN} drt_link_t;
endpackage
`default_nettype wire

// File: tb/drt_smb_host.sv
// smbus master model: makes the link clock and pulls the data line
`default_nettype none
module drt_smb_host #(
  parameter logic [6:0] SLAVE_ADDR = drt_pkg::SLAVE_ADDR
) (
  // bus lines
  output var logic scl,
  output var logic sda_pull,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // 8 MHz link clock, high and still outside frames
  localparam real HALF = 62.5;
  int misses;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    misses = 0;
  end
  // ***************************
  // frame conditions
  // ***************************
  // long high phases so the system-clock synchroniser sees start and stop
  task automatic start_c();
    sda_pull = 1'b0;
    #(HALF);
    scl = 1'b1;
    #500;
    sda_pull = 1'b1;
    #500;
    scl = 1'b0;
  endtask
  task automatic stop_c();
    #20;
    sda_pull = 1'b1;
    #(HALF);
    scl = 1'b1;
    #500;
    sda_pull = 1'b0;
    #1500;
  endtask
  // ***************************
  // bits and bytes
  // ***************************
  task automatic bit_out(input logic b);
    #20;
    sda_pull = ~b;
    #(HALF - 20);
    scl = 1'b1;
    #(HALF);
    scl = 1'b0;
  endtask
  task automatic bit_in(output logic b);
    #20;
    sda_pull = 1'b0;
    #(HALF - 20);
    scl = 1'b1;
    b = sda;
    #(HALF);
    scl = 1'b0;
  endtask
  task automatic tx_byte(input logic [7:0] d, output logic nak);
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(nak);
  endtask
  task automatic tx_ok(input logic [7:0] d);
    logic nak;
    tx_byte(d, nak);
    if (nak !== 1'b0) misses++;
  endtask
  task automatic rx_byte(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(1'b1);
  endtask
  // ***************************
  // register access
  // ***************************
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
    start_c();
    tx_ok({SLAVE_ADDR, 1'b0});
    tx_ok(cmd);
    tx_ok(d);
    stop_c();
  endtask
  task automatic rd(input logic [7:0] cmd, output logic [7:0] d);
    start_c();
    tx_ok({SLAVE_ADDR, 1'b0});
    tx_ok(cmd);
    start_c();
    tx_ok({SLAVE_ADDR, 1'b1});
    rx_byte(d);
    stop_c();
  endtask
  task automatic rd_cur(output logic [7:0] d);
    start_c();
    tx_ok({SLAVE_ADDR, 1'b1});
    rx_byte(d);
    stop_c();
  endtask
endmodule
`default_nettype wire

// File: tb/test_drt_core.sv
// self-checking bench for the sensor core
`default_nettype none
module test_drt_core;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CH = 400;
  localparam int IDLE = 60;
  localparam int PASS = 3 * CH;
  logic clk_sys, reset, scl, pull, sda, dat_o, oe_n, f1, f2, a;
  logic signed [16:0] loc_s, rem1_s, rem2_s;
  logic [1:0] chan, model, comp, prev_chan;
  logic [7:0] v;
  int miscompares, n_checks;
  // open drain with pull-up
  assign sda = ~pull & (oe_n | dat_o);
  drt_core #(.CH_CYC(CH), .IDLE_CYC(IDLE), .TMO_CYC(200)) dut (
    .clk_sys(clk_sys), .reset(reset), .smb_clk(scl), .smb_dat_i(sda),
    .smb_dat_o(dat_o), .smb_dat_oe_n(oe_n), .loc_sample(loc_s), .rem1_sample(rem1_s),
    .rem2_sample(rem2_s), .diode1_fault(f1), .diode2_fault(f2), .conv_chan(chan),
    .diode_model(model), .ideality_comp(comp));
  drt_smb_host host (.scl(scl), .sda_pull(pull), .sda(sda));
  initial clk_sys = 1'b0;
  always #25 clk_sys = ~clk_sys;
  // ***************************
  // checking and closing
  // ***************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] cmd, input logic [7:0] exp, input string what);
    logic [7:0] d;
    host.rd(cmd, d);
    check(d, exp, what);
  endtask
  task automatic passwait();
    repeat (2 * PASS + 2 * IDLE + 100) @(posedge clk_sys);
  endtask
  // cycles between two starts of the remote-1 slot
  task automatic measure(input int exp);
    int n;
    int seen;
    logic [1:0] last;
    n = 0;
    seen = 0;
    last = chan;
    for (int k = 0; k < 3 * exp && seen < 2; k++) begin
      @(negedge clk_sys);
      if (seen > 0) n++;
      if (chan === 2'd1 && last === 2'd0) seen++;
      last = chan;
    end
    check({7'h0, n >= exp && n <= exp + 4}, 8'h01, "pass period");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial prev_chan = 2'd0;
  // look away from the edge that moves the channel
  always @(negedge clk_sys) begin
    if (!reset && chan !== prev_chan) begin
      check({6'h0, chan}, {6'h0, prev_chan == 2'd2 ? 2'd0 : prev_chan + 2'd1}, "order");
    end
    prev_chan <= chan;
  end
  initial begin
    #4ms;
    miscompares++;
    print_verdict();
  end
  // ***************************
  // tests
  // ***************************
  initial begin
    reset = 1'b1;
    loc_s = 17'sd6410;
    rem1_s = -17'sd6400;
    rem2_s = 17'sd11;
    f1 = 1'b0;
    f2 = 1'b1;
    miscompares = 0;
    n_checks = 0;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (4) @(posedge clk_sys);
    check({6'h0, model}, 8'h01, "model pins");
    check({6'h0, comp}, 8'h01, "comp pins");
    host.rd_cur(v);
    check(v, 8'h00, "pointer");
    rdchk(drt_pkg::REG_REM1_HI, 8'h00, "rem1 before conversion");
    rdchk(drt_pkg::REG_STATUS, 8'h81, "busy and fault");
    rdchk(drt_pkg::REG_CONFIG, 8'h00, "config reset");
    rdchk(drt_pkg::REG_FILTER, 8'h05, "filter reset");
    host.wr(drt_pkg::REG_MODEL, 8'h03);
    host.wr(drt_pkg::REG_COMP, 8'h03);
    check({6'h0, model}, 8'h03, "model written");
    check({6'h0, comp}, 8'h03, "comp written");
    rdchk(drt_pkg::REG_MODEL, 8'h03, "model readback");
    @(posedge clk_sys);
    f2 <= 1'b0;
    passwait();
    measure(PASS);
    rdchk(drt_pkg::REG_LOC_HI, 8'h19, "local hi");
    rdchk(drt_pkg::REG_LOC_LO, 8'h00, "local lo");
    rdchk(drt_pkg::REG_REM1_HI, 8'he7, "rem1 hi");
    rdchk(drt_pkg::REG_REM1_LO, 8'h00, "rem1 lo");
    rdchk(drt_pkg::REG_REM2_HI, 8'h00, "rem2 hi");
    rdchk(drt_pkg::REG_REM2_LO, 8'h08, "rem2 lo");
    $display("test power-up and 13-bit done");
    host.wr(drt_pkg::REG_FILTER, 8'h00);
    host.wr(drt_pkg::REG_CONFIG, 8'h04);
    @(posedge clk_sys);
    rem1_s <= -17'sd256;
    rem2_s <= 17'sd65504;
    passwait();
    rdchk(drt_pkg::REG_REM1_HI, 8'hff, "rem1 hi");
    rdchk(drt_pkg::REG_REM1_LO, 8'h00, "rem1 lo");
    rdchk(drt_pkg::REG_REM2_HI, 8'hff, "rem2 hi");
    rdchk(drt_pkg::REG_REM2_LO, 8'he0, "rem2 lo");
    $display("test 11-bit done");
    @(posedge clk_sys);
    rem1_s <= 17'sd288;
    passwait();
    rdchk(drt_pkg::REG_REM1_HI, 8'h01, "hi locks");
    @(posedge clk_sys);
    rem1_s <= 17'sd576;
    passwait();
    rdchk(drt_pkg::REG_REM1_LO, 8'h20, "lo frozen");
    rdchk(drt_pkg::REG_REM1_LO, 8'h40, "lo free");
    rdchk(drt_pkg::REG_REM1_HI, 8'h02, "hi locks");
    @(posedge clk_sys);
    rem1_s <= 17'sd864;
    passwait();
    rdchk(drt_pkg::REG_REM1_HI, 8'h03, "hi relocks");
    @(posedge clk_sys);
    rem1_s <= 17'sd288;
    passwait();
    rdchk(drt_pkg::REG_REM1_LO, 8'h60, "lo replaced");
    $display("test low byte lock done");
    host.wr(drt_pkg::REG_CONFIG, 8'h40);
    passwait();
    rdchk(drt_pkg::REG_STATUS, 8'h00, "idle in standby");
    @(posedge clk_sys);
    loc_s <= 17'sd256;
    passwait();
    rdchk(drt_pkg::REG_LOC_HI, 8'h19, "standby holds");
    host.wr(drt_pkg::REG_ONESHOT, 8'h00);
    passwait();
    rdchk(drt_pkg::REG_LOC_HI, 8'h01, "one-shot result");
    rdchk(drt_pkg::REG_ONESHOT, 8'h00, "one-shot reads zero");
    host.wr(drt_pkg::REG_CONFIG, 8'h10);
    measure(PASS + IDLE);
    @(posedge clk_sys);
    f1 <= 1'b1;
    passwait();
    rdchk(drt_pkg::REG_REM1_HI, 8'h80, "rem1 fault signed");
    rdchk(drt_pkg::REG_REM1_LO, 8'h00, "rem1 fault lo");
    host.wr(drt_pkg::REG_CONFIG, 8'h12);
    passwait();
    rdchk(drt_pkg::REG_REM1_HI, 8'hff, "rem1 fault unsigned");
    rdchk(drt_pkg::REG_REM1_LO, 8'he0, "rem1 fault unsigned lo");
    @(posedge clk_sys);
    f1 <= 1'b0;
    $display("test standby and rate done");
    host.start_c();
    host.tx_byte({drt_pkg::SLAVE_ADDR ^ 7'h01, 1'b0}, a);
    check({7'h0, a}, 8'h01, "foreign address");
    host.stop_c();
    host.start_c();
    for (int i = 7; i >= 0; i--) host.bit_out(i == 0 ? 1'b0 : drt_pkg::SLAVE_ADDR[i - 1]);
    #200;
    check({7'h0, oe_n}, 8'h00, "ack driven");
    #15000;
    check({7'h0, oe_n}, 8'h01, "released");
    host.stop_c();
    rdchk(drt_pkg::REG_CONFIG, 8'h12, "bus usable");
    check(host.misses[7:0], 8'h00, "acks");
    $display("test address and timeout done");
    print_verdict();
  end
endmodule
`default_nettype wire
